// ===== pcr_pkg.sv
package pcr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LOOP_CONTROL_OFS = 8'h1E;
  localparam logic [7:0] REF_DIVIDER_CONFIG_OFS = 8'h1F;
  localparam logic [7:0] MONITOR_PIN_CONFIG_OFS = 8'h20;

  localparam logic [7:0] LOOP_CONTROL_RST = 8'h48;
  localparam logic [7:0] REF_DIVIDER_CONFIG_RST = 8'h01;
  localparam logic [7:0] MONITOR_PIN_CONFIG_RST = 8'h14;

  // Writable bits; every other bit is reserved and reads as zero.
  localparam logic [7:0] LOOP_CONTROL_MASK = 8'hFD;
  localparam logic [7:0] REF_DIVIDER_CONFIG_MASK = 8'h1F;
  localparam logic [7:0] MONITOR_PIN_CONFIG_MASK = 8'hFC;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PUMP_CURRENT_MSB = 7;
  localparam int PUMP_CURRENT_LSB = 4;
  localparam int PD_POLARITY_BIT = 3;
  localparam int PLL_POWER_DOWN_BIT = 2;
  localparam int COUNTER_HOLD_BIT = 0;
  localparam int REF_DIVIDE_MSB = 4;
  localparam int REF_DIVIDE_LSB = 0;
  localparam int SOURCE_SEL_MSB = 7;
  localparam int SOURCE_SEL_LSB = 4;
  localparam int READBACK_SEL_BIT = 3;
  localparam int LOGIC_LEVEL_BIT = 2;

  // ----------------------------------------------------------------
  // Monitor pin source codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_TRISTATE = 4'h0;
  localparam logic [3:0] SRC_LOCK_DETECT = 4'h1;
  localparam logic [3:0] SRC_PUMP_UP = 4'h2;
  localparam logic [3:0] SRC_PUMP_DOWN = 4'h3;
  localparam logic [3:0] SRC_HALVED_REF = 4'h4;
  localparam logic [3:0] SRC_FEEDBACK_DIV = 4'h5;
  localparam logic [3:0] SRC_VCO_TEST = 4'h6;
  localparam logic [3:0] SRC_RESERVED = 4'h7;
  localparam logic [3:0] SRC_HIGH = 4'h8;
  localparam logic [3:0] SRC_CAL_R_BAND = 4'h9;
  localparam logic [3:0] SRC_CAL_N_BAND = 4'hA;

endpackage

// ===== pcr_cfg_reg.sv
`timescale 1ns/10ps
module pcr_cfg_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] value
);

  logic [7:0] value_nxt;

  // Reserved bits are masked off on both write and reset.
  assign value_nxt = wrData & WR_MASK;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      value <= RESET_VAL & WR_MASK;
    end else if (wrEn) begin
      value <= value_nxt;
    end
  end

endmodule

// ===== pcr_regs.sv
// Notes on behaviour
// - Pump current code bits 7:4, reset 4.
// - Polarity bit 3, reset 1 means positive.
// - Power-down bit 2 stops PLL blocks only.
// - Power-down never changes stored register values.
// - Counter hold bit 0 resets both dividers.
// - Reference divider five bits, reset 1.
// - Source select bits 7:4 pick monitor signal.
// - Tristate only when readback select is 0.
// - Readback select bit 3 steers readback pin.
// - Level bit 2 picks 1.8 V or 3.3 V.
`timescale 1ns/10ps
module pcr_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic readActive,
  input wire logic readBit,
  input wire logic lockDetect,
  input wire logic pumpUp,
  input wire logic pumpDown,
  input wire logic halvedReferenceClock,
  input wire logic feedbackDivOut,
  input wire logic vcoTestOut,
  input wire logic calRBandHalf,
  input wire logic calNBandHalf,
  output logic [7:0] regRdData,
  output logic [3:0] pumpCurrentCode,
  output logic phaseDetectorPolaritySel,
  output logic pllPowerDown,
  output logic dividerCounterHold,
  output logic [4:0] refDivideValue,
  output logic testPinLogicLevel,
  output logic sdioOut,
  output logic sdioOe,
  output logic monitorOut,
  output logic monitorOe
);
  import pcr_pkg::*;

  // ----------------------------------------------------------------
  // Address decode and register storage
  // ----------------------------------------------------------------
  logic hitLoop;
  logic hitRef;
  logic hitMon;
  logic [7:0] loopReg;
  logic [7:0] refReg;
  logic [7:0] monReg;

  assign hitLoop = regAddr == LOOP_CONTROL_OFS;
  assign hitRef = regAddr == REF_DIVIDER_CONFIG_OFS;
  assign hitMon = regAddr == MONITOR_PIN_CONFIG_OFS;

  // Power-down is only a field here; nothing clears the other registers
  // on entering or leaving it, so programmed values survive.
  pcr_cfg_reg #(
    .RESET_VAL(LOOP_CONTROL_RST),
    .WR_MASK(LOOP_CONTROL_MASK)
  ) loopCtlReg (
    .clk(clk),
    .nrst(nrst),
    .wrEn(regWrEn && hitLoop),
    .wrData(regWrData),
    .value(loopReg)
  );

  pcr_cfg_reg #(
    .RESET_VAL(REF_DIVIDER_CONFIG_RST),
    .WR_MASK(REF_DIVIDER_CONFIG_MASK)
  ) refDivReg (
    .clk(clk),
    .nrst(nrst),
    .wrEn(regWrEn && hitRef),
    .wrData(regWrData),
    .value(refReg)
  );

  pcr_cfg_reg #(
    .RESET_VAL(MONITOR_PIN_CONFIG_RST),
    .WR_MASK(MONITOR_PIN_CONFIG_MASK)
  ) monPinReg (
    .clk(clk),
    .nrst(nrst),
    .wrEn(regWrEn && hitMon),
    .wrData(regWrData),
    .value(monReg)
  );

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic [3:0] sourceSel;
  logic readbackSel;
  logic [7:0] rdMux;

  assign sourceSel = monReg[SOURCE_SEL_MSB:SOURCE_SEL_LSB];
  assign readbackSel = monReg[READBACK_SEL_BIT];

  // Unmapped addresses read as zero.
  assign rdMux = hitLoop ? loopReg :
                 hitRef ? refReg :
                 hitMon ? monReg : 8'h00;

  // ----------------------------------------------------------------
  // Monitor pin source selection
  // ----------------------------------------------------------------
  logic srcLevel;
  logic srcDrive;

  always_comb begin
    srcLevel = 1'h0;
    srcDrive = 1'h1;
    case (sourceSel)
      SRC_TRISTATE: begin
        // High impedance only while the pin is not the readback path.
        srcDrive = readbackSel;
      end
      SRC_LOCK_DETECT: srcLevel = lockDetect;
      SRC_PUMP_UP: srcLevel = pumpUp;
      SRC_PUMP_DOWN: srcLevel = pumpDown;
      SRC_HALVED_REF: srcLevel = halvedReferenceClock;
      SRC_FEEDBACK_DIV: srcLevel = feedbackDivOut;
      SRC_VCO_TEST: srcLevel = vcoTestOut;
      SRC_RESERVED: srcLevel = 1'h0;
      SRC_HIGH: srcLevel = 1'h1;
      SRC_CAL_R_BAND: srcLevel = calRBandHalf;
      SRC_CAL_N_BAND: srcLevel = calNBandHalf;
      default: srcLevel = 1'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Readback routing
  // ----------------------------------------------------------------
  logic monitorOut_nxt;
  logic monitorOe_nxt;
  logic sdioOe_nxt;

  // While a read shifts out, the selected pin carries the data bit.
  assign sdioOe_nxt = readActive && !readbackSel;
  assign monitorOut_nxt = (readActive && readbackSel) ? readBit : srcLevel;
  assign monitorOe_nxt = (readActive && readbackSel) ? 1'h1 : srcDrive;

  // Pin outputs are registered, so they lag the sources by one cycle;
  // the pump pulses seen here are therefore sampled, not exact.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
      sdioOut <= 1'h0;
      sdioOe <= 1'h0;
      monitorOut <= 1'h0;
      monitorOe <= 1'h0;
    end else begin
      if (regRdEn) begin
        regRdData <= rdMux;
      end
      sdioOut <= readBit;
      sdioOe <= sdioOe_nxt;
      monitorOut <= monitorOut_nxt;
      monitorOe <= monitorOe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs to the analog loop
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pumpCurrentCode <= LOOP_CONTROL_RST[PUMP_CURRENT_MSB:PUMP_CURRENT_LSB];
      phaseDetectorPolaritySel <= LOOP_CONTROL_RST[PD_POLARITY_BIT];
      pllPowerDown <= LOOP_CONTROL_RST[PLL_POWER_DOWN_BIT];
      dividerCounterHold <= LOOP_CONTROL_RST[COUNTER_HOLD_BIT];
      refDivideValue <= REF_DIVIDER_CONFIG_RST[REF_DIVIDE_MSB:REF_DIVIDE_LSB];
      testPinLogicLevel <= MONITOR_PIN_CONFIG_RST[LOGIC_LEVEL_BIT];
    end else begin
      pumpCurrentCode <= loopReg[PUMP_CURRENT_MSB:PUMP_CURRENT_LSB];
      phaseDetectorPolaritySel <= loopReg[PD_POLARITY_BIT];
      pllPowerDown <= loopReg[PLL_POWER_DOWN_BIT];
      dividerCounterHold <= loopReg[COUNTER_HOLD_BIT];
      refDivideValue <= refReg[REF_DIVIDE_MSB:REF_DIVIDE_LSB];
      testPinLogicLevel <= monReg[LOGIC_LEVEL_BIT];
    end
  end

endmodule

// ===== pcr_regs_asserts.sv
`timescale 1ns/10ps
module pcr_regs_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic readActive,
  input wire logic readBit,
  input wire logic [7:0] regRdData,
  input wire logic [3:0] pumpCurrentCode,
  input wire logic phaseDetectorPolaritySel,
  input wire logic pllPowerDown,
  input wire logic dividerCounterHold,
  input wire logic [4:0] refDivideValue,
  input wire logic testPinLogicLevel,
  input wire logic sdioOut,
  input wire logic sdioOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence sWr(a);
    regWrEn && regAddr == a;
  endsequence
  AST_RST_VAL: assert property ($rose(nrst) |-> {pumpCurrentCode,
    phaseDetectorPolaritySel, pllPowerDown, dividerCounterHold, refDivideValue,
    testPinLogicLevel} == 13'h0903) else $error("reset value");
  AST_LOOP_WR: assert property (sWr(8'h1E) |-> ##2 {pumpCurrentCode,
    phaseDetectorPolaritySel, pllPowerDown, dividerCounterHold}
    == {$past(regWrData[7:2], 2), $past(regWrData[0], 2)}) else $error("loop fields");
  AST_REF_WR: assert property (sWr(8'h1F) |-> ##2 refDivideValue ==
    $past(regWrData[4:0], 2)) else $error("ref divider");
  AST_LVL_WR: assert property (sWr(8'h20) |-> ##2 testPinLogicLevel ==
    $past(regWrData[2], 2)) else $error("pin level");
  AST_RD_UNMAP: assert property (regRdEn && !(regAddr inside {8'h1E, 8'h1F, 8'h20})
    |=> regRdData == 8'h00) else $error("unmapped read");
  AST_PD_KEEP: assert property ($changed(pllPowerDown) |-> $stable(refDivideValue))
    else $error("power-down lost data");
  AST_SDIO_IDLE: assert property (!readActive |=> !sdioOe) else $error("sdio enable");
  AST_SDIO_BIT: assert property (sdioOe |-> sdioOut == $past(readBit))
    else $error("sdio bit");
endmodule
bind pcr_regs pcr_regs_asserts pcr_regs_asserts_inst (.clk, .nrst, .regAddr, .regWrEn,
  .regWrData, .regRdEn, .readActive, .readBit, .regRdData, .pumpCurrentCode,
  .phaseDetectorPolaritySel, .pllPowerDown, .dividerCounterHold, .refDivideValue,
  .testPinLogicLevel, .sdioOut, .sdioOe);

// ===== pcr_host_model.sv
`timescale 1ns/10ps
module pcr_host_model (
  input wire logic clk,
  input wire logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  output logic readActive,
  output logic readBit
);
  initial begin
    {regAddr, regWrEn, regWrData, regRdEn, readActive, readBit} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    // Stale data is inverted so that a late sample cannot match by luck.
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(posedge clk);
    #1 d = regRdData;
  endtask
  task automatic wake(input logic [7:0] loopVal);
    wr(8'h1E, loopVal);
    wr(8'h10, 8'h00);
  endtask
  task automatic shift(input logic a, input logic b);
    @(posedge clk);
    readActive <= a;
    readBit <= b;
  endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk, nrst, regWrEn, regRdEn, readActive, readBit, sdioOut, sdioOe;
  logic monitorOut, monitorOe, phaseDetectorPolaritySel, pllPowerDown;
  logic dividerCounterHold, testPinLogicLevel;
  logic [7:0] src, regAddr, regWrData, regRdData;
  logic [3:0] pumpCurrentCode;
  logic [4:0] refDivideValue;
  int mismatches, checks_done;
  wire [7:0] loopOut = {pumpCurrentCode, phaseDetectorPolaritySel, pllPowerDown, 1'b0,
    dividerCounterHold};
  wire [7:0] pins = {5'h0, sdioOe, monitorOe, monitorOut};
  pcr_host_model pcr_host_model_inst (.clk, .regRdData, .regAddr, .regWrEn, .regWrData,
    .regRdEn, .readActive, .readBit);
  pcr_regs pcr_regs_inst (.clk, .nrst, .regAddr, .regWrEn, .regWrData, .regRdEn, .readActive,
    .readBit, .lockDetect(src[0]), .pumpUp(src[1]), .pumpDown(src[2]),
    .halvedReferenceClock(src[3]), .feedbackDivOut(src[4]), .vcoTestOut(src[5]),
    .calRBandHalf(src[6]), .calNBandHalf(src[7]), .regRdData, .pumpCurrentCode,
    .phaseDetectorPolaritySel, .pllPowerDown, .dividerCounterHold, .refDivideValue,
    .testPinLogicLevel, .sdioOut, .sdioOe, .monitorOut, .monitorOe);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pcr_host_model_inst.wr(a, d);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    pcr_host_model_inst.rd(a, d);
    chk(d, e);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic shift(input logic a, input logic b);
    pcr_host_model_inst.shift(a, b);
    @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    chk(loopOut, 8'h48);
    rdChk(8'h1F, 8'h01);
    rdChk(8'h20, 8'h14);
  endtask
  task automatic t_write();
    logic [7:0] d;
    for (int i = 0; i < 2; i++) begin
      d = i ? 8'h21 : 8'hFF;
      wr(8'h1E, d);
      wr(8'h1F, d);
      wr(8'h20, d);
      settle();
      chk(loopOut, d & 8'hFD);
      chk({3'h0, refDivideValue}, d & 8'h1F);
      chk({7'h0, testPinLogicLevel}, {7'h0, d[2]});
      rdChk(8'h1E, d & 8'hFD);
      rdChk(8'h20, d & 8'hFC);
    end
    wr(8'h21, 8'hFF);
    rdChk(8'h21, 8'h00);
  endtask
  task automatic t_pd();
    wr(8'h1F, 8'h0A);
    wr(8'h1E, 8'h04);
    settle();
    chk({7'h0, pllPowerDown}, 8'h01);
    rdChk(8'h1F, 8'h0A);
    pcr_host_model_inst.wake(8'h48);
    settle();
    chk(loopOut, 8'h48);
    rdChk(8'h1F, 8'h0A);
  endtask
  task automatic t_mux();
    logic [1:0] e;
    logic [7:0] p;
    for (int k = 0; k < 2; k++) begin
      p = k ? 8'h5A : 8'hA5;
      @(posedge clk);
      src <= p;
      for (int c = 0; c < 16; c++) begin
        wr(8'h20, {c[3:0], 4'h4});
        settle();
        case (c)
          0: e = 2'b00;
          1, 2, 3, 4, 5, 6: e = {1'b1, p[c - 1]};
          8: e = 2'b11;
          9, 10: e = {1'b1, p[c - 3]};
          default: e = 2'b10;
        endcase
        chk({6'h0, monitorOe, monitorOut}, {6'h0, e});
      end
    end
  endtask
  task automatic t_rdback();
    @(posedge clk);
    src <= 8'h00;
    wr(8'h20, 8'h14);
    settle();
    shift(1'b1, 1'b1);
    chk(pins, 8'h06);
    chk({7'h0, sdioOut}, 8'h01);
    shift(1'b1, 1'b0);
    chk({7'h0, sdioOut}, 8'h00);
    wr(8'h20, 8'h08);
    settle();
    shift(1'b1, 1'b1);
    chk(pins, 8'h03);
    shift(1'b0, 1'b0);
    chk(pins, 8'h02);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    nrst = 1'b0;
    src = 8'h00;
    mismatches = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_write();
    t_pd();
    t_mux();
    t_rdback();
    tally_and_finish();
  end
endmodule
